/* hw/spc_pkg.sv */
// Package with the constants, register map and types of the segment privilege checker.
// Behaviour
// (R1) Privilege levels run from 0 to 3, and a larger number always means less privilege.
// (R2) In compatibility mode every segment protection check, the limit check among them, stays active.
// (R3) In 64-bit mode limit checks are skipped except for accesses to system-descriptor tables.
// (R4) The current level is held in a register that software cannot read and changes only on a code-segment transfer.
// (R5) The descriptor level is taken from the descriptor itself.
// (R6) The requestor level is taken from the selector that references the descriptor.
// (R7) A data-segment load forms an effective level, the larger of the current and requestor levels.
// (R8) If the effective level is not above the descriptor level, the selector and descriptor are loaded.
// (R9) If the effective level is above the descriptor level, a protection fault is raised and nothing is loaded.
// (R10) A stack-segment load needs the requestor level equal to the current level, else it faults unloaded.
// (R11) A stack-segment load also needs the descriptor level equal to the current level, else it faults unloaded.
// (R12) All three levels are 2-bit unsigned fields compared as unsigned numbers.
package spc_pkg;

	localparam int PRIV_W = 2;
	typedef logic [PRIV_W-1:0] spc_priv_t;
	localparam spc_priv_t PRIV_MOST = 2'h0;
	localparam spc_priv_t PRIV_LEAST = 2'h3;

	localparam int SEL_W = 16;
	localparam int DESC_W = 64;
	localparam int REQ_LVL_LSB = 0;
	localparam int DESC_LVL_LSB = 45;

	localparam int TGT_W = 3;
	localparam int NUM_SEGS = 5;
	localparam logic [TGT_W-1:0] TGT_DATA_A = 3'h0;
	localparam logic [TGT_W-1:0] TGT_DATA_B = 3'h1;
	localparam logic [TGT_W-1:0] TGT_DATA_C = 3'h2;
	localparam logic [TGT_W-1:0] TGT_DATA_D = 3'h3;
	localparam logic [TGT_W-1:0] TGT_STACK = 3'h4;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SEG_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] REG_SEG_LAST = 8'h20;
	localparam int SEG_IDX_LSB = 2;

	localparam int CTRL_MODE64 = 0;
	localparam int ST_DATA_FAULT = 0;
	localparam int ST_STACK_FAULT = 1;
	localparam int ST_LIMIT_FAULT = 2;
	localparam int ST_W = 3;
	localparam logic [ST_W-1:0] ST_RESET = 3'h0;
	localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		SPC_RD_IDLE = 3'b001,
		SPC_RD_WAIT = 3'b010,
		SPC_RD_RESP = 3'b100
	} spc_rd_state_t;

endpackage : spc_pkg

/* hw/spc_seg_mem.sv */
// Small register-read memory that holds the visible selector and hidden descriptor of each segment register.
`timescale 1ns/10ps
`default_nettype none
module spc_seg_mem
	import spc_pkg::*;
#(
	parameter int WIDTH = SEL_W + DESC_W,
	parameter int DEPTH = NUM_SEGS,
	parameter int AW = TGT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd_data;
	} spc_mem_state_t;

	spc_mem_state_t s_reg;
	spc_mem_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			s_next.mem[wr_addr] = wr_data;
		end
		if (int'(rd_addr) < DEPTH) begin
			s_next.rd_data = s_reg.mem[rd_addr];
		end else begin
			s_next.rd_data = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data = s_reg.rd_data;

endmodule : spc_seg_mem
`default_nettype wire

/* hw/spc_segment_privilege_check.sv */
// Segment-register load privilege checker with limit check and an AXI4-Lite register slave.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module spc_segment_privilege_check
	import spc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic code_xfer_valid,
	input wire spc_priv_t code_xfer_level,
	input wire logic seg_load_valid,
	input wire logic [TGT_W-1:0] seg_load_target,
	input wire logic [SEL_W-1:0] seg_load_selector,
	input wire logic [DESC_W-1:0] seg_load_descriptor,
	input wire logic limit_chk_valid,
	input wire logic limit_chk_sys_table,
	input wire logic [31:0] limit_chk_offset,
	input wire logic [31:0] limit_chk_limit,
	output logic seg_load_done,
	output logic general_protection_fault,
	output logic limit_fault,
	output logic irq
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [ADDR_W-1:0] araddr;
		spc_rd_state_t rd_state;
		logic mode64;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic irq;
		spc_priv_t current_priv_level;
		logic done;
		logic prot_fault;
		logic lim_fault;
	} spc_state_t;

	spc_state_t s_reg;
	spc_state_t s_next;

	logic mem_wr_en;
	logic [TGT_W-1:0] mem_rd_addr;
	logic [SEL_W+DESC_W-1:0] mem_rd_data;

	function automatic spc_priv_t requestor_priv_level(input logic [SEL_W-1:0] sel);
		requestor_priv_level = sel[REQ_LVL_LSB +: PRIV_W]; // see (R6)
	endfunction : requestor_priv_level

	function automatic spc_priv_t descriptor_priv_level(input logic [DESC_W-1:0] desc);
		descriptor_priv_level = desc[DESC_LVL_LSB +: PRIV_W]; // see (R5)
	endfunction : descriptor_priv_level

	function automatic spc_priv_t level_max(input spc_priv_t a, input spc_priv_t b);
		level_max = (a > b) ? a : b; // see (R1) (R12)
	endfunction : level_max

	function automatic logic is_data_target(input logic [TGT_W-1:0] t);
		is_data_target = (t == TGT_DATA_A) || (t == TGT_DATA_B) || (t == TGT_DATA_C) || (t == TGT_DATA_D);
	endfunction : is_data_target

	function automatic logic is_seg_addr(input logic [ADDR_W-1:0] a);
		is_seg_addr = (a >= REG_SEG_BASE) && (a <= REG_SEG_LAST);
	endfunction : is_seg_addr

	function automatic logic [TGT_W-1:0] seg_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = (a - REG_SEG_BASE) >> SEG_IDX_LSB;
		seg_index = d[TGT_W-1:0];
	endfunction : seg_index

	spc_priv_t req_lvl;
	spc_priv_t desc_lvl;
	spc_priv_t eff_level;
	logic is_data_tgt;
	logic is_stack_tgt;
	logic load_ok;
	logic load_fault;
	logic lim_bad;
	logic [ST_W-1:0] st_set;
	logic [ST_W-1:0] st_clr;
	logic wr_do;
	logic ar_take;

	always_comb begin
		req_lvl = requestor_priv_level(seg_load_selector);
		desc_lvl = descriptor_priv_level(seg_load_descriptor);
		// Larger number is the lesser privilege, so the effective level is the unsigned maximum.
		eff_level = level_max(req_lvl, s_reg.current_priv_level); // see (R7) (R1) (R12)
		is_data_tgt = is_data_target(seg_load_target);
		is_stack_tgt = (seg_load_target == TGT_STACK);
		load_ok = 1'b0;
		load_fault = 1'b0;
		if (seg_load_valid && is_data_tgt) begin
			load_ok = (eff_level <= desc_lvl); // see (R8) (R12)
			load_fault = (eff_level > desc_lvl); // see (R9)
		end else if (seg_load_valid && is_stack_tgt) begin
			load_ok = (req_lvl == s_reg.current_priv_level) // see (R10)
				&& (desc_lvl == s_reg.current_priv_level); // see (R11)
			load_fault = !load_ok; // see (R10) (R11)
		end
		// Limit checks stay on outside 64-bit mode; in 64-bit mode only system tables are checked.
		lim_bad = limit_chk_valid && (limit_chk_offset > limit_chk_limit)
			&& (!s_reg.mode64 || limit_chk_sys_table); // see (R2) (R3)
		mem_wr_en = load_ok; // see (R8) (R9)
		mem_rd_addr = seg_index(s_axi_araddr);
		wr_do = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
		ar_take = s_axi_arvalid && s_reg.arready;
	end

	spc_seg_mem #(
		.WIDTH(SEL_W + DESC_W),
		.DEPTH(NUM_SEGS),
		.AW(TGT_W)
	) u_seg_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(mem_wr_en),
		.wr_addr(seg_load_target),
		.wr_data({seg_load_selector, seg_load_descriptor}),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data)
	);

	always_comb begin
		s_next = s_reg;
		st_set = '0;
		st_clr = '0;
		s_next.done = seg_load_valid;
		s_next.prot_fault = load_fault; // see (R9) (R10) (R11)
		s_next.lim_fault = lim_bad; // see (R3)
		st_set[ST_DATA_FAULT] = load_fault && is_data_tgt;
		st_set[ST_STACK_FAULT] = load_fault && is_stack_tgt;
		st_set[ST_LIMIT_FAULT] = lim_bad;

		// The current level moves only when a code-segment transfer brings a new level.
		if (code_xfer_valid) begin
			s_next.current_priv_level = code_xfer_level; // see (R4)
		end

		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end

		if (wr_do) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			unique case (s_reg.awaddr)
				REG_CTRL: begin
					if (s_reg.wstrb[0]) begin
						s_next.mode64 = s_reg.wdata[CTRL_MODE64];
					end
				end
				REG_STATUS: begin
					if (s_reg.wstrb[0]) begin
						st_clr = s_reg.wdata[ST_W-1:0];
					end
				end
				REG_MASK: begin
					if (s_reg.wstrb[0]) begin
						s_next.mask = s_reg.wdata[ST_W-1:0];
					end
				end
				default: begin
					s_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end

		// Hardware events win over a write-one clear landing in the same cycle.
		s_next.status = (s_reg.status & ~st_clr) | st_set;
		s_next.irq = |(s_next.status & s_next.mask);
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;

		unique case (s_reg.rd_state)
			SPC_RD_IDLE: begin
				if (ar_take) begin
					s_next.araddr = s_axi_araddr;
					s_next.arready = 1'b0;
					s_next.rd_state = SPC_RD_WAIT;
				end
			end
			SPC_RD_WAIT: begin
				s_next.rvalid = 1'b1;
				s_next.rresp = RESP_OKAY;
				s_next.rdata = DATA_ZERO;
				s_next.rd_state = SPC_RD_RESP;
				if (is_seg_addr(s_reg.araddr) && (s_reg.araddr[SEG_IDX_LSB-1:0] == 2'h0)) begin
					s_next.rdata[SEL_W-1:0] = mem_rd_data[SEL_W+DESC_W-1:DESC_W];
				end else if (s_reg.araddr == REG_CTRL) begin
					s_next.rdata[CTRL_MODE64] = s_reg.mode64;
				end else if (s_reg.araddr == REG_STATUS) begin
					s_next.rdata[ST_W-1:0] = s_reg.status;
				end else if (s_reg.araddr == REG_MASK) begin
					s_next.rdata[ST_W-1:0] = s_reg.mask;
				end else begin
					s_next.rresp = RESP_SLVERR;
				end
			end
			SPC_RD_RESP: begin
				if (s_axi_rready) begin
					s_next.rvalid = 1'b0;
					s_next.arready = 1'b1;
					s_next.rd_state = SPC_RD_IDLE;
				end
			end
			default: begin
				s_next.rvalid = 1'b0;
				s_next.arready = 1'b1;
				s_next.rd_state = SPC_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Every field takes a constant, so nothing survives a reset in mid-run.
			s_reg.bvalid <= 1'b0;
			s_reg.aw_got <= 1'b0;
			s_reg.w_got <= 1'b0;
			s_reg.awaddr <= '0;
			s_reg.wdata <= DATA_ZERO;
			s_reg.wstrb <= '0;
			s_reg.rvalid <= 1'b0;
			s_reg.rdata <= DATA_ZERO;
			s_reg.araddr <= '0;
			s_reg.mode64 <= 1'b0;
			s_reg.irq <= 1'b0;
			s_reg.done <= 1'b0;
			s_reg.prot_fault <= 1'b0;
			s_reg.lim_fault <= 1'b0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.bresp <= RESP_OKAY;
			s_reg.rresp <= RESP_OKAY;
			s_reg.rd_state <= SPC_RD_IDLE;
			s_reg.status <= ST_RESET;
			s_reg.mask <= MASK_RESET;
			s_reg.current_priv_level <= PRIV_MOST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rdata = s_reg.rdata;
	assign seg_load_done = s_reg.done;
	assign general_protection_fault = s_reg.prot_fault;
	assign limit_fault = s_reg.lim_fault;
	assign irq = s_reg.irq;

endmodule : spc_segment_privilege_check
`default_nettype wire

/* test/spc_cpu_model.sv */
// Model of the execution and descriptor fetch side that issues loads, transfers and limit checks.
`timescale 1ns/10ps
`default_nettype none
module spc_cpu_model
	import spc_pkg::*;
(
	input wire logic aclk,
	input wire logic seg_load_done,
	input wire logic general_protection_fault,
	input wire logic limit_fault,
	output logic code_xfer_valid,
	output spc_priv_t code_xfer_level,
	output logic seg_load_valid,
	output logic [TGT_W-1:0] seg_load_target,
	output logic [SEL_W-1:0] seg_load_selector,
	output logic [DESC_W-1:0] seg_load_descriptor,
	output logic limit_chk_valid,
	output logic limit_chk_sys_table,
	output logic [31:0] limit_chk_offset,
	output logic [31:0] limit_chk_limit
);
	initial begin
		{code_xfer_valid, code_xfer_level, seg_load_valid, seg_load_target} = '0;
		{seg_load_selector, seg_load_descriptor, limit_chk_valid, limit_chk_sys_table} = '0;
		{limit_chk_offset, limit_chk_limit} = '0;
	end
	task automatic xfer(input spc_priv_t l);
		@(posedge aclk);
		code_xfer_valid <= 1'b1;
		code_xfer_level <= l;
		@(posedge aclk);
		code_xfer_valid <= 1'b0;
		code_xfer_level <= ~l;
	endtask : xfer
	task automatic load(input logic [TGT_W-1:0] t, input logic [SEL_W-1:0] s, input spc_priv_t d,
		output logic dn, output logic f);
		logic [DESC_W-1:0] desc_word;
		desc_word = 64'h5a5a_0000_a5a5_0f0f;
		desc_word[DESC_LVL_LSB+:PRIV_W] = d;
		@(posedge aclk);
		seg_load_valid <= 1'b1;
		seg_load_target <= t;
		seg_load_selector <= s;
		seg_load_descriptor <= desc_word;
		@(posedge aclk);
		seg_load_valid <= 1'b0;
		seg_load_selector <= ~s;
		seg_load_descriptor <= ~desc_word;
		#1;
		dn = seg_load_done;
		f = general_protection_fault;
	endtask : load
	task automatic limit(input logic sys, input logic [31:0] o, input logic [31:0] m, output logic f);
		@(posedge aclk);
		limit_chk_valid <= 1'b1;
		limit_chk_sys_table <= sys;
		limit_chk_offset <= o;
		limit_chk_limit <= m;
		@(posedge aclk);
		limit_chk_valid <= 1'b0;
		limit_chk_offset <= ~o;
		#1;
		f = limit_fault;
	endtask : limit
endmodule : spc_cpu_model
`default_nettype wire

/* test/spc_segment_privilege_check_assertions.sv */
// Concurrent checks on the ports of the segment privilege checker.
`timescale 1ns/10ps
`default_nettype none
module spc_segment_privilege_check_assertions
	import spc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic code_xfer_valid,
	input wire spc_priv_t code_xfer_level,
	input wire logic seg_load_valid,
	input wire logic [TGT_W-1:0] seg_load_target,
	input wire logic [SEL_W-1:0] seg_load_selector,
	input wire logic [DESC_W-1:0] seg_load_descriptor,
	input wire logic limit_chk_valid,
	input wire logic limit_chk_sys_table,
	input wire logic [31:0] limit_chk_offset,
	input wire logic [31:0] limit_chk_limit,
	input wire logic seg_load_done,
	input wire logic general_protection_fault,
	input wire logic limit_fault,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	spc_priv_t lvl_reg;
	spc_priv_t lvl_next;
	spc_priv_t req_lvl;
	spc_priv_t desc_lvl;
	spc_priv_t eff;
	logic ld;
	logic stk;
	always_comb begin
		lvl_next = code_xfer_valid ? code_xfer_level : lvl_reg;
		req_lvl = seg_load_selector[REQ_LVL_LSB+:PRIV_W];
		desc_lvl = seg_load_descriptor[DESC_LVL_LSB+:PRIV_W];
		eff = (lvl_reg > req_lvl) ? lvl_reg : req_lvl;
		ld = seg_load_valid && (seg_load_target < TGT_STACK);
		stk = seg_load_valid && (seg_load_target == TGT_STACK);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_reg <= PRIV_MOST;
		end else begin
			lvl_reg <= lvl_next;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_done_one_cycle: assert property (seg_load_valid |=> seg_load_done)
		else $error("load not answered");
	a_no_stray_done: assert property (!seg_load_valid |=> !seg_load_done && !general_protection_fault)
		else $error("stray done or fault");
	a_data_fault: assert property (ld && eff > desc_lvl |=> general_protection_fault)
		else $error("data fault missed");
	a_data_pass: assert property (ld && eff <= desc_lvl |=> !general_protection_fault)
		else $error("data load refused");
	a_stack_req: assert property (stk && req_lvl != lvl_reg |=> general_protection_fault)
		else $error("stack requestor level");
	a_stack_desc: assert property (stk && desc_lvl != lvl_reg |=> general_protection_fault)
		else $error("stack descriptor level");
	a_stack_pass: assert property (stk && req_lvl == lvl_reg && desc_lvl == lvl_reg |=> !general_protection_fault)
		else $error("stack load refused");
	a_limit_sys: assert property (limit_chk_valid && limit_chk_sys_table && limit_chk_offset > limit_chk_limit
		|=> limit_fault) else $error("table limit missed");
	a_limit_quiet: assert property (!limit_chk_valid || limit_chk_offset <= limit_chk_limit |=> !limit_fault)
		else $error("stray limit fault");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	c_data_fault: cover property (ld && eff > desc_lvl);
	c_stack_pass: cover property (stk && req_lvl == lvl_reg && desc_lvl == lvl_reg);
	c_limit_fault: cover property (limit_fault);
endmodule : spc_segment_privilege_check_assertions
`default_nettype wire

/* test/spc_segment_privilege_check_tb_top.sv */
// Self-checking testbench for the segment privilege checker.
`timescale 1ns/10ps
`default_nettype none
module spc_segment_privilege_check_tb_top
	import spc_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, limit_chk_offset, limit_chk_limit;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, limit_fault;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic code_xfer_valid, seg_load_valid, limit_chk_valid, limit_chk_sys_table, seg_load_done;
	logic general_protection_fault, dn, f, e;
	spc_priv_t code_xfer_level;
	logic [TGT_W-1:0] seg_load_target, tg;
	logic [SEL_W-1:0] seg_load_selector;
	logic [DESC_W-1:0] seg_load_descriptor;
	logic [31:0] d;
	int err_count = 0;
	int cmp_count = 0;
	always #12.5 aclk = ~aclk;
	spc_segment_privilege_check spc_segment_privilege_check_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .code_xfer_valid, .code_xfer_level, .seg_load_valid,
		.seg_load_target, .seg_load_selector, .seg_load_descriptor, .limit_chk_valid, .limit_chk_sys_table,
		.limit_chk_offset, .limit_chk_limit, .seg_load_done, .general_protection_fault, .limit_fault, .irq);
	spc_cpu_model spc_cpu_model_i (.aclk, .seg_load_done, .general_protection_fault, .limit_fault, .code_xfer_valid,
		.code_xfer_level, .seg_load_valid, .seg_load_target, .seg_load_selector, .seg_load_descriptor,
		.limit_chk_valid, .limit_chk_sys_table, .limit_chk_offset, .limit_chk_limit);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task finish_test;
		$display("Checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	initial begin
		#500_000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(REG_STATUS, d, r);
		check(d, DATA_ZERO);
		axr(8'h40, d, r);
		check(d, DATA_ZERO);
		check(32'(r), 32'(RESP_SLVERR));
		for (int s = 0; s < 2; s++) begin
			for (int l = 0; l < 4; l++) begin
				spc_cpu_model_i.xfer(2'(l));
				for (int q = 0; q < 4; q++) begin
					for (int p = 0; p < 4; p++) begin
						tg = (s == 1) ? TGT_STACK : 3'((q + p) % 4);
						e = (s == 1) ? (q != l || p != l) : (((l > q) ? l : q) > p);
						spc_cpu_model_i.load(tg, {8'h5a, 6'(l), 2'(q)}, 2'(p), dn, f);
						check(32'({dn, f}), 32'({1'b1, e}));
					end
				end
			end
		end
		spc_cpu_model_i.xfer(2'h0);
		spc_cpu_model_i.load(TGT_DATA_B, 16'hbee1, 2'h2, dn, f);
		spc_cpu_model_i.load(TGT_DATA_B, 16'hc0d3, 2'h0, dn, f);
		spc_cpu_model_i.load(3'h5, 16'h0003, 2'h0, dn, f);
		check(32'({dn, f}), 32'h0000_0002);
		axr(REG_SEG_BASE + 8'h04, d, r);
		check(d, 32'h0000_bee1);
		axr(REG_STATUS, d, r);
		check(d, 32'h0000_0003);
		check(32'(irq), DATA_ZERO);
		axw(REG_MASK, 32'h0000_0007, r);
		axr(REG_MASK, d, r);
		check(d, 32'h0000_0007);
		check(32'(irq), 32'h0000_0001);
		axw(REG_STATUS, 32'h0000_0001, r);
		axr(REG_STATUS, d, r);
		check(d, 32'h0000_0002);
		check(32'(irq), 32'h0000_0001);
		axw(REG_STATUS, 32'h0000_0002, r);
		axr(REG_STATUS, d, r);
		check(d, DATA_ZERO);
		check(32'(irq), DATA_ZERO);
		spc_cpu_model_i.limit(1'b0, 32'h0000_0010, 32'h0000_000f, f);
		check(32'(f), 32'h0000_0001);
		spc_cpu_model_i.limit(1'b0, 32'h0000_000f, 32'h0000_000f, f);
		check(32'(f), 32'h0000_0000);
		axw(REG_CTRL, 32'h0000_0001, r);
		axr(REG_CTRL, d, r);
		check(d, 32'h0000_0001);
		spc_cpu_model_i.limit(1'b0, 32'h0000_0010, 32'h0000_000f, f);
		check(32'(f), 32'h0000_0000);
		spc_cpu_model_i.limit(1'b1, 32'h0000_0010, 32'h0000_000f, f);
		check(32'(f), 32'h0000_0001);
		axr(REG_STATUS, d, r);
		check(d, 32'h0000_0004);
		check(32'(irq), 32'h0000_0001);
		axw(REG_SEG_BASE, 32'h0000_1234, r);
		check(32'(r), 32'(RESP_SLVERR));
		axw(8'h40, 32'h0000_1234, r);
		check(32'(r), 32'(RESP_SLVERR));
		spc_cpu_model_i.xfer(2'h3);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(REG_CTRL, d, r);
		check(d, DATA_ZERO);
		axr(REG_SEG_BASE + 8'h04, d, r);
		check(d, DATA_ZERO);
		spc_cpu_model_i.load(TGT_STACK, 16'h0000, 2'h0, dn, f);
		check(32'({dn, f}), 32'h0000_0002);
		finish_test();
	end
endmodule : spc_segment_privilege_check_tb_top
bind spc_segment_privilege_check spc_segment_privilege_check_assertions spc_chk_i (.aclk, .aresetn, .code_xfer_valid,
	.code_xfer_level, .seg_load_valid, .seg_load_target, .seg_load_selector, .seg_load_descriptor, .limit_chk_valid,
	.limit_chk_sys_table, .limit_chk_offset, .limit_chk_limit, .seg_load_done, .general_protection_fault,
	.limit_fault, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire
